// ---- logic/timer_consts.svh ----
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
`define OFS_UNIT_CTRL      8'h00
`define OFS_PRESCALE       8'h04
`define OFS_CHAN_MODE      8'h08
`define OFS_RELOAD         8'h0c
`define OFS_COUNTER        8'h10
`define OFS_TRIGGER        8'h14
`define OFS_STATUS         8'h18
`define OFS_OUT_LEVELS     8'h1c
`define OFS_OUT_ENABLES    8'h20
`define OFS_OUT_POLARITY   8'h24
`define OFS_OUT_MODES      8'h28
`define BIT_START          0
`define BIT_STOP           1
`define BIT_CLK_SEL        0
`define BIT_MODE_DIV       1
`define BIT_START_IRQ      2
`define POS_EDGE_SEL       3
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10
`endif

// ---- logic/timer_pkg.sv ----
package timer_pkg;
	typedef enum logic [1:0] {
		EDGE_FALL = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_BOTH = 2'h2
	} edge_sel_e;
	typedef enum logic [2:0] {
		CH_IDLE  = 3'b001,
		CH_ARMED = 3'b010,
		CH_RUN   = 3'b100
	} chan_state_e;
endpackage

// ---- logic/edge_if.sv ----
`timescale 1ns/10ps
interface edge_if;
	logic       sample_en;
	logic [1:0] edge_sel;
	logic       event_seen;
	modport det (input sample_en, input edge_sel, output event_seen);
	modport use_side (output sample_en, output edge_sel, input event_seen);
endinterface

// ---- logic/input_edge_detect.sv ----
`timescale 1ns/10ps
module input_edge_detect
	import timer_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic clear,
	input  wire logic pin,
	edge_if.det       ev
);
	logic sync1_q, sync2_q, prev_q, seen_q;
	logic sync1_d, sync2_d, prev_d, seen_d;

	// Two-stage synchroniser, then edges sampled at the operating clock rate.
	always_comb begin
		sync1_d = pin;
		sync2_d = sync1_q;
		prev_d  = prev_q;
		seen_d  = 1'b0;
		if (clear) begin
			prev_d = sync2_q;
		end else if (ev.sample_en) begin
			prev_d = sync2_q;
			case (ev.edge_sel)
				EDGE_RISE: seen_d = sync2_q & ~prev_q;
				EDGE_FALL: seen_d = ~sync2_q & prev_q;
				EDGE_BOTH: seen_d = sync2_q ^ prev_q;
				default:   seen_d = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
			seen_q  <= 1'b0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			prev_q  <= prev_d;
			seen_q  <= seen_d;
		end
	end

	assign ev.event_seen = seen_q;
endmodule

// ---- logic/timer_event_counter_freq_divider.sv ----
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "timer_consts.svh"
// What this block does
// - Gate off stops clock, ignores register writes except to unit control.
// - Gate off resets all channel registers; bus slave and input synchroniser keep theirs.
// - Prescaler fixes two operating clock rates.
// - Start sets enable; counter mode loads reload.
// - Start trigger clears itself after write.
// - Counter mode: decrement, interrupt, reload at zero.
// - Reload writable, counter readable while running.
// - Stop clears enable, counter holds, self-clears.
// - Divider loads at first edge; select gates toggle.
// - Divider toggles output and reloads at zero.
// - Output divides input by (reload+1) times two.
// - Period error up to one operating clock.
// - New reload takes effect next period.
// - Output register bit sets output level.
// - Output enable lets counting change output.
module timer_event_counter_freq_divider
	import timer_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RST_B,
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	input  wire logic        TIMER_INPUT_PIN,
	output logic             TIMER_OUTPUT_PIN,
	output logic             CHANNEL_INTERRUPT
);
	logic        gate_q, gate_d;
	logic [7:0]  prescale_q, prescale_d;
	logic [4:0]  mode_q, mode_d;
	logic [15:0] reload_value_q, reload_value_d;
	logic [15:0] down_counter_q, down_counter_d;
	logic        channel_enable_status_q, channel_enable_status_d;
	logic [7:0]  out_levels_q, out_levels_d;
	logic [7:0]  out_enables_q, out_enables_d;
	logic [7:0]  out_polarity_q, out_polarity_d;
	logic [7:0]  out_modes_q, out_modes_d;
	logic        irq_q, irq_d;
	logic [15:0] div_q, div_d;
	logic        tick_a_q, tick_a_d, tick_b_q, tick_b_d;
	chan_state_e state_q, state_d;
	logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [7:0]  awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic        do_write, start_trig, stop_trig;
	edge_if      ev();

	function automatic logic known_addr(input logic [7:0] a);
		case (a)
			`OFS_UNIT_CTRL, `OFS_PRESCALE, `OFS_CHAN_MODE, `OFS_RELOAD, `OFS_COUNTER,
			`OFS_TRIGGER, `OFS_STATUS, `OFS_OUT_LEVELS, `OFS_OUT_ENABLES,
			`OFS_OUT_POLARITY, `OFS_OUT_MODES: known_addr = 1'b1;
			default: known_addr = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave. Writes complete once both address and data are held.

	assign do_write = aw_held_q && w_held_q && !bvalid_q;

	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d  = w_held_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		if (AWVALID && !aw_held_q) begin
			aw_held_d = 1'b1;
			awaddr_d  = AWADDR;
		end
		if (WVALID && !w_held_q) begin
			w_held_d = 1'b1;
			wdata_d  = WDATA;
			wstrb_d  = WSTRB;
		end
		if (do_write) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = known_addr(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (bvalid_q && BREADY) begin
			bvalid_d = 1'b0;
		end
		if (ARVALID && !rvalid_q) begin
			rvalid_d = 1'b1;
			rresp_d  = known_addr(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
			case (ARADDR)
				`OFS_UNIT_CTRL:    rdata_d = {31'h0, gate_q};
				`OFS_PRESCALE:     rdata_d = {24'h0, prescale_q};
				`OFS_CHAN_MODE:    rdata_d = {27'h0, mode_q};
				`OFS_RELOAD:       rdata_d = {16'h0, reload_value_q};
				`OFS_COUNTER:      rdata_d = {16'h0, down_counter_q};
				`OFS_STATUS:       rdata_d = {31'h0, channel_enable_status_q};
				`OFS_OUT_LEVELS:   rdata_d = {24'h0, out_levels_q};
				`OFS_OUT_ENABLES:  rdata_d = {24'h0, out_enables_q};
				`OFS_OUT_POLARITY: rdata_d = {24'h0, out_polarity_q};
				`OFS_OUT_MODES:    rdata_d = {24'h0, out_modes_q};
				default:           rdata_d = 32'h0;
			endcase
		end else if (rvalid_q && RREADY) begin
			rvalid_d = 1'b0;
		end
		awready_d = !aw_held_d;
		wready_d  = !w_held_d;
		arready_d = !rvalid_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler: operating clock a uses the low nibble, b the high nibble.

	always_comb begin
		div_d    = gate_q ? div_q + 16'h1 : 16'h0;
		tick_a_d = gate_q && (prescale_q[3:0] == 4'h0 ||
			div_q[prescale_q[3:0] - 4'h1 +: 1] == 1'b0 && div_d[prescale_q[3:0] - 4'h1 +: 1]);
		tick_b_d = gate_q && (prescale_q[7:4] == 4'h0 ||
			div_q[prescale_q[7:4] - 4'h1 +: 1] == 1'b0 && div_d[prescale_q[7:4] - 4'h1 +: 1]);
	end

	assign ev.sample_en = mode_q[`BIT_CLK_SEL] ? tick_b_q : tick_a_q;
	assign ev.edge_sel  = mode_q[`POS_EDGE_SEL +: 2];

	input_edge_detect u_edge (
		.clk   (REF_CLK),
		.rst_b (RST_B),
		.clear (!channel_enable_status_q),
		.pin   (TIMER_INPUT_PIN),
		.ev    (ev)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Registers and channel sequencing.

	assign start_trig = do_write && awaddr_q == `OFS_TRIGGER && wdata_q[`BIT_START];
	assign stop_trig  = do_write && awaddr_q == `OFS_TRIGGER && wdata_q[`BIT_STOP];

	always_comb begin
		gate_d                  = gate_q;
		prescale_d              = prescale_q;
		mode_d                  = mode_q;
		reload_value_d          = reload_value_q;
		down_counter_d          = down_counter_q;
		channel_enable_status_d = channel_enable_status_q;
		out_levels_d            = out_levels_q;
		out_enables_d           = out_enables_q;
		out_polarity_d          = out_polarity_q;
		out_modes_d             = out_modes_q;
		state_d                 = state_q;
		irq_d                   = 1'b0;
		if (do_write && awaddr_q == `OFS_UNIT_CTRL) begin
			gate_d = wdata_q[0];
		end
		if (gate_q && do_write && wstrb_q != 4'h0) begin
			case (awaddr_q)
				`OFS_PRESCALE:     prescale_d = wdata_q[7:0];
				`OFS_CHAN_MODE:    mode_d = wdata_q[4:0];
				`OFS_RELOAD:       reload_value_d = wdata_q[15:0];
				`OFS_OUT_LEVELS:   out_levels_d = wdata_q[7:0];
				`OFS_OUT_ENABLES:  out_enables_d = wdata_q[7:0];
				`OFS_OUT_POLARITY: out_polarity_d = wdata_q[7:0];
				`OFS_OUT_MODES:    out_modes_d = wdata_q[7:0];
				default:           mode_d = mode_q;
			endcase
		end
		case (state_q)
			CH_IDLE: begin
				if (gate_q && start_trig) begin
					channel_enable_status_d = 1'b1;
					if (mode_q[`BIT_MODE_DIV]) begin
						state_d = CH_ARMED;
					end else begin
						down_counter_d = reload_value_q;
						state_d = CH_RUN;
					end
				end
			end
			CH_ARMED: begin
				if (ev.event_seen) begin
					down_counter_d = reload_value_q;
					state_d = CH_RUN;
					if (mode_q[`BIT_START_IRQ]) begin
						irq_d = 1'b1;
						out_levels_d[0] = out_enables_q[0] ? ~out_levels_q[0] : out_levels_q[0];
					end
				end
			end
			CH_RUN: begin
				if (ev.event_seen) begin
					if (down_counter_q == 16'h0) begin
						down_counter_d = reload_value_q;
						if (mode_q[`BIT_MODE_DIV]) begin
							out_levels_d[0] = out_enables_q[0] ? ~out_levels_q[0] : out_levels_q[0];
						end
						irq_d = 1'b1;
					end else begin
						down_counter_d = down_counter_q - 16'h1;
					end
				end
			end
			default: state_d = CH_IDLE;
		endcase
		if (gate_q && stop_trig) begin
			channel_enable_status_d = 1'b0;
			state_d = CH_IDLE;
			down_counter_d = down_counter_q;
		end
		if (!gate_q) begin
			prescale_d = 8'h0;
			mode_d = 5'h0;
			reload_value_d = 16'h0;
			down_counter_d = 16'h0;
			channel_enable_status_d = 1'b0;
			out_levels_d = 8'h0;
			out_enables_d = 8'h0;
			out_polarity_d = 8'h0;
			out_modes_d = 8'h0;
			state_d = CH_IDLE;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			gate_q <= 1'b0;
			prescale_q <= 8'h0;
			mode_q <= 5'h0;
			reload_value_q <= 16'h0;
			down_counter_q <= 16'h0;
			channel_enable_status_q <= 1'b0;
			out_levels_q <= 8'h0;
			out_enables_q <= 8'h0;
			out_polarity_q <= 8'h0;
			out_modes_q <= 8'h0;
			irq_q <= 1'b0;
			div_q <= 16'h0;
			tick_a_q <= 1'b0;
			tick_b_q <= 1'b0;
			state_q <= CH_IDLE;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
		end else begin
			gate_q <= gate_d;
			prescale_q <= prescale_d;
			mode_q <= mode_d;
			reload_value_q <= reload_value_d;
			down_counter_q <= down_counter_d;
			channel_enable_status_q <= channel_enable_status_d;
			out_levels_q <= out_levels_d;
			out_enables_q <= out_enables_d;
			out_polarity_q <= out_polarity_d;
			out_modes_q <= out_modes_d;
			irq_q <= irq_d;
			div_q <= div_d;
			tick_a_q <= tick_a_d;
			tick_b_q <= tick_b_d;
			state_q <= state_d;
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
		end
	end

	assign AWREADY = awready_q;
	assign WREADY = wready_q;
	assign BVALID = bvalid_q;
	assign BRESP = bresp_q;
	assign ARREADY = arready_q;
	assign RVALID = rvalid_q;
	assign RRESP = rresp_q;
	assign RDATA = rdata_q;
	assign TIMER_OUTPUT_PIN = out_levels_q[0];
	assign CHANNEL_INTERRUPT = irq_q;
endmodule

// ---- bench/timer_edge_source.sv ----
`timescale 1ns/10ps
module timer_edge_source (
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [7:0] n_edges,
	input  wire logic       slow,
	output logic            pin,
	output logic            busy
);
	int left = 0;
	int hold = 0;
	initial pin = 1'b0;
	assign busy = left != 0;
	// Each level is held several cycles so the sampler cannot miss it.
	always @(posedge clk) begin
		if (left == 0) begin
			if (go) left <= n_edges;
			hold <= 2;
		end else if (hold == 0) begin
			pin <= !pin;
			left <= left - 1;
			hold <= slow ? 6 : 2;
		end else hold <= hold - 1;
	end
endmodule

// ---- bench/timer_event_counter_freq_divider_asserts.sv ----
`timescale 1ns/10ps
`include "timer_consts.svh"
module timer_event_counter_freq_divider_asserts (
	input wire logic        REF_CLK,
	input wire logic        RST_B,
	input wire logic [7:0]  AWADDR,
	input wire logic        AWVALID,
	input wire logic        AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0]  WSTRB,
	input wire logic        WVALID,
	input wire logic        WREADY,
	input wire logic [1:0]  BRESP,
	input wire logic        BVALID,
	input wire logic        BREADY,
	input wire logic [7:0]  ARADDR,
	input wire logic        ARVALID,
	input wire logic        ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0]  RRESP,
	input wire logic        RVALID,
	input wire logic        RREADY,
	input wire logic        TIMER_INPUT_PIN,
	input wire logic        TIMER_OUTPUT_PIN,
	input wire logic        CHANNEL_INTERRUPT
);
	logic       in_q, in_d;
	logic [3:0] quiet_q, quiet_d;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	// Cycles since the input pin last changed, saturating.
	always_comb begin
		in_d = TIMER_INPUT_PIN;
		quiet_d = (TIMER_INPUT_PIN != in_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
	end
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			in_q <= 1'b0;
			quiet_q <= 4'hf;
		end else begin
			in_q <= in_d;
			quiet_q <= quiet_d;
		end
	end
	////////////////////////////////////////////////////////////////
	property p_irq_pulse; CHANNEL_INTERRUPT |=> !CHANNEL_INTERRUPT; endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt too long");
	property p_irq_cause; CHANNEL_INTERRUPT |-> quiet_q < 4'hc; endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt w/o edge");
	property p_out_cause;
		$changed(TIMER_OUTPUT_PIN) |-> quiet_q < 4'hc || BVALID || $past(BVALID) || $past(BVALID, 2);
	endproperty
	a_out_cause: assert property (p_out_cause) else $error("output moved w/o cause");
	property p_bresp; AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID; endproperty
	a_bresp: assert property (p_bresp) else $error("write response late");
	property p_bhold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_ar_block; ARVALID && ARREADY |=> RVALID && !ARREADY; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read accepted while busy");
	property p_unmapped;
		ARVALID && ARREADY && ARADDR > `OFS_OUT_MODES |=> RRESP == `RESP_SLVERR && RDATA == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
	property p_trig_zero; ARVALID && ARREADY && ARADDR == `OFS_TRIGGER |=> RDATA == 32'h0; endproperty
	a_trig_zero: assert property (p_trig_zero) else $error("trigger reads nonzero");
	c_irq: cover property (CHANNEL_INTERRUPT);
	c_toggle: cover property ($changed(TIMER_OUTPUT_PIN) && !BVALID);
	c_unmapped: cover property (RVALID && RRESP == `RESP_SLVERR);
endmodule
bind timer_event_counter_freq_divider timer_event_counter_freq_divider_asserts chk (.*);

// ---- bench/timer_event_counter_freq_divider_tb_top.sv ----
`timescale 1ns/10ps
`include "timer_consts.svh"
module timer_event_counter_freq_divider_tb_top
	import timer_pkg::*;
;
	logic        REF_CLK = 1'b0, RST_B = 1'b0, slow = 1'b0, go = 1'b0;
	logic [7:0]  AWADDR = 8'h0, ARADDR = 8'h0, n_edges = 8'h0;
	logic [31:0] WDATA = 32'h0, RDATA, d, seed = 32'h647050e6;
	logic [3:0]  WSTRB = 4'hf;
	logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, busy;
	logic        TIMER_INPUT_PIN, TIMER_OUTPUT_PIN, CHANNEL_INTERRUPT;
	logic [1:0]  BRESP, RRESP, rr;
	int          mismatches = 0, n_checks = 0, m_irq = 0, irq_seen = 0, m_cnt, m_rel, n;
	bit          m_run = 0, m_arm = 0, m_oe = 0, m_sel = 0, m_out = 0, lvl = 0;
	edge_sel_e   es_t [3] = '{EDGE_RISE, EDGE_BOTH, EDGE_FALL};
	bit          sel_t [3] = '{1'b0, 1'b1, 1'b1};
	bit          oe_t [3] = '{1'b1, 1'b1, 1'b0};
	timer_event_counter_freq_divider dut (.*);
	timer_edge_source src (.clk(REF_CLK), .go(go), .n_edges(n_edges), .slow(slow),
		.pin(TIMER_INPUT_PIN), .busy(busy));
	always #10 REF_CLK = ~REF_CLK;
	always @(posedge REF_CLK) if (CHANNEL_INTERRUPT === 1'b1) irq_seen++;
	////////////////////////////////////////////////////////////////
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wait_bound(input bit hit);
		if (hit) begin
			mismatches++;
			report_and_stop;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge REF_CLK);
		AWADDR <= a;
		WDATA <= v;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (n = 0; n < 64 && BVALID !== 1'b1; n++) begin
			@(posedge REF_CLK);
			if (AWREADY === 1'b1) AWVALID <= 1'b0;
			if (WREADY === 1'b1) WVALID <= 1'b0;
		end
		BREADY <= 1'b0;
		wait_bound(n == 64);
	endtask
	task rd(input logic [7:0] a);
		@(posedge REF_CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (n = 0; n < 64 && RVALID !== 1'b1; n++) begin
			@(posedge REF_CLK);
			if (ARREADY === 1'b1) ARVALID <= 1'b0;
		end
		d = RDATA;
		rr = RRESP;
		RREADY <= 1'b0;
		wait_bound(n == 64);
	endtask
	task bump;
		m_irq++;
		if (m_oe) m_out = !m_out;
	endtask
	// Reference channel: one call for each valid edge.
	task ev;
		if (m_arm) begin
			m_arm = 0;
			m_cnt = m_rel;
			if (m_sel) bump();
		end else if (m_cnt == 0) begin
			m_cnt = m_rel;
			bump();
		end else m_cnt--;
	endtask
	task edges(input int k, input int es);
		for (int i = 0; i < k; i++) begin
			lvl = !lvl;
			if (m_run && (es == 2 || (es == 1) == lvl)) ev();
		end
		d = xs();
		@(posedge REF_CLK);
		n_edges <= k[7:0];
		slow <= d[0];
		go <= 1'b1;
		@(posedge REF_CLK);
		go <= 1'b0;
		@(posedge REF_CLK);
		for (n = 0; n < 200 && busy !== 1'b0; n++) @(posedge REF_CLK);
		wait_bound(n == 200);
		repeat (12) @(posedge REF_CLK);
	endtask
	initial begin
		repeat (6) @(posedge REF_CLK);
		RST_B <= 1'b1;
		wr(`OFS_RELOAD, 32'h5);
		wr(`OFS_UNIT_CTRL, 32'h1);
		rd(`OFS_RELOAD);
		chk(d, 32'h0);
		rd(8'h40);
		chk(rr, `RESP_SLVERR);
		wr(`OFS_PRESCALE, 32'h10);
		rd(`OFS_PRESCALE);
		chk(d, 32'h10);
		wr(`OFS_OUT_MODES, 32'h0);
		wr(`OFS_OUT_POLARITY, 32'h0);
		d = xs();
		m_rel = 2 + d[1:0];
		wr(`OFS_CHAN_MODE, {27'h0, EDGE_RISE, 3'h0});
		wr(`OFS_RELOAD, m_rel);
		wr(`OFS_OUT_ENABLES, 32'h0);
		wr(`OFS_TRIGGER, 32'h1);
		m_run = 1;
		m_cnt = m_rel;
		rd(`OFS_TRIGGER);
		chk(d, 32'h0);
		rd(`OFS_STATUS);
		chk(d, 32'h1);
		rd(`OFS_COUNTER);
		chk(d, m_cnt);
		edges(7, 1);
		rd(`OFS_COUNTER);
		chk(d, m_cnt);
		chk(irq_seen, m_irq);
		wr(`OFS_RELOAD, 32'h1);
		m_rel = 1;
		edges(6, 1);
		rd(`OFS_COUNTER);
		chk(d, m_cnt);
		chk(irq_seen, m_irq);
		wr(`OFS_TRIGGER, 32'h2);
		m_run = 0;
		rd(`OFS_STATUS);
		chk(d, 32'h0);
		edges(3, 1);
		rd(`OFS_COUNTER);
		chk(d, m_cnt);
		for (int s = 0; s < 3; s++) begin
			wr(`OFS_OUT_LEVELS, 32'h1);
			@(posedge REF_CLK);
			chk(TIMER_OUTPUT_PIN, 32'h1);
			wr(`OFS_OUT_LEVELS, 32'h0);
			m_out = 0;
			wr(`OFS_CHAN_MODE, {27'h0, es_t[s], sel_t[s], 1'b1, 1'(s == 1)});
			wr(`OFS_OUT_ENABLES, {31'h0, oe_t[s]});
			wr(`OFS_TRIGGER, 32'h1);
			m_run = 1;
			m_arm = 1;
			m_sel = sel_t[s];
			m_oe = oe_t[s];
			edges(9 + s, es_t[s]);
			chk(TIMER_OUTPUT_PIN, m_out);
			chk(irq_seen, m_irq);
			rd(`OFS_COUNTER);
			chk(d, m_cnt);
			wr(`OFS_TRIGGER, 32'h2);
			m_run = 0;
		end
		wr(`OFS_OUT_LEVELS, 32'h1);
		wr(`OFS_UNIT_CTRL, 32'h0);
		wr(`OFS_UNIT_CTRL, 32'h1);
		rd(`OFS_RELOAD);
		chk(d, 32'h0);
		chk(TIMER_OUTPUT_PIN, 32'h0);
		report_and_stop;
	end
endmodule
